/* File: lcdm_pkg.sv */
/*
  Constants shared by the display mode control block: register
  indices and byte addresses, field positions, reset values and codes.
  Assumes a 32-bit AXI4-Lite register bus with one register per word.
*/
package lcdm_pkg;
  // Register indices; byte address is four times the index
  localparam int         LCDM_FMT_IDX    = 2;
  localparam int         LCDM_PWR_IDX    = 3;
  localparam logic [7:0] LCDM_FMT_ADDR   = 8'(LCDM_FMT_IDX * 4);
  localparam logic [7:0] LCDM_PWR_ADDR   = 8'(LCDM_PWR_IDX * 4);

  // Display format control fields
  localparam int         LCDM_BPP_LO     = 6;
  localparam int         LCDM_HPERF      = 5;
  localparam int         LCDM_CLK_HALF   = 4;
  localparam int         LCDM_BLANK      = 3;
  localparam int         LCDM_FRAME_REP  = 2;
  localparam int         LCDM_HW_INV     = 1;
  localparam int         LCDM_SW_INV     = 0;

  // Power control fields
  localparam int         LCDM_PWR_OVR    = 3;
  localparam int         LCDM_HW_PS_EN   = 2;
  localparam int         LCDM_SW_PS_LO   = 0;

  // Reset values and implemented-bit masks
  localparam logic [7:0] LCDM_FMT_RST    = 8'h00;
  localparam logic [7:0] LCDM_PWR_RST    = 8'h00;
  localparam logic [7:0] LCDM_PWR_MASK   = 8'h0F;

  // Codes
  localparam logic [1:0] LCDM_BPP_8      = 2'h3;
  localparam logic [1:0] LCDM_SWPS_SAVE  = 2'h0;
  localparam logic [1:0] LCDM_SWPS_RUN   = 2'h3;
  localparam logic [17:0] LCDM_FRAME_MAX = 18'h3FFFF;
  localparam logic [1:0] LCDM_RESP_OKAY  = 2'h0;
  localparam logic [1:0] LCDM_RESP_SLVERR = 2'h2;
endpackage

/* File: lcdm_tick_div.sv */
/*
  Tick divider: passes one in every 2**div_sel input ticks.
  Assumes tick_in is a one-cycle strobe in the core clock domain.
*/
`timescale 1ns/1ps
module lcdm_tick_div #(
  parameter int SEL_W = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             tick_in,
  input  wire logic [SEL_W-1:0] div_sel,
  output logic                  tick_out
);
  localparam int CNT_W = (1 << SEL_W) - 1;

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] mask;

  generate
    if (SEL_W < 1 || SEL_W > 3)
    begin : g_chk
      $error("lcdm_tick_div: SEL_W must be 1 to 3");
    end
  endgenerate

  always_comb
  begin
    mask     = CNT_W'((1 << div_sel) - 1);
    tick_out = tick_in && ((cnt_ff & mask) == mask);
    nxt_cnt  = tick_in ? cnt_ff + 1'b1 : cnt_ff;
  end

  // Free-running count; a new ratio takes effect at once, so the first gap may be short
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule

/* File: lcdm_mode_ctrl.sv */
/*
  Display mode control: format and power control registers on an
  AXI4-Lite slave, clock tick generation, inversion/blank pixel stage,
  frame repeat counter and pin muxing of pixel bit eleven and io zero.
  Assumes core_clk is the input clock and all inputs are synchronous.
*/
// Function
// - The two-bit depth field selects 1, 2, 4 or 8 bits per pixel, with code 11 reserved on mono panels.
// - With high performance off, memory ticks are pixel ticks divided by 8, 4, 2 or 1 for 1, 2, 4, 8 bpp.
// - With high performance on, memory ticks equal pixel ticks at every depth.
// - In rotated view the high performance bit is ignored and the rotated clock selection is used.
// - The divide bit makes the operating clock the input clock or half of it.
// - In landscape the pixel clock equals the operating clock.
// - The blank bit drives all panel pixel lines low.
// - With frame repeat on, an 18-bit frame counter wraps at 3FFFFh and restarts the pattern.
// - In passive modes pixel bit eleven is the invert input when hardware invert is on, else io four.
// - The software invert bit selects inverse video.
// - On passive panels, hardware invert enable hands the inversion choice from the software bit to pixel bit eleven.
// - Inversion is applied to pixel data after the look-up table.
// - With override set, power goes off and interface signals go low on entering power save.
// - Hardware power save enable turns io zero into an active-high power save input.
// - Software power save code 00 selects power save and 11 normal operation.
`timescale 1ns/1ps
module lcdm_mode_ctrl
  import lcdm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic          core_clk,
  input  wire logic          rst_b,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Panel and mode context
  input  wire logic          color_panel,
  input  wire logic          active_panel,
  input  wire logic          rotated_view,
  input  wire logic          rotated_mem_tick,
  output logic [1:0]         bpp_code,
  output logic [3:0]         bits_per_pixel,
  output logic               depth_reserved,
  output logic               op_clk_tick,
  output logic               pixel_clk_tick,
  output logic               mem_clk_tick,
  // Pixel path
  input  wire logic [11:0]   lut_pixel,
  output logic [10:0]        panel_pixel_lines,
  input  wire logic          panel_pixel_bit_eleven_in,
  output logic               panel_pixel_bit_eleven_out,
  output logic               panel_pixel_bit_eleven_oe,
  input  wire logic          general_io_four_out_req,
  input  wire logic          general_io_four_oe_req,
  output logic               general_io_four_in,
  output logic               video_invert,
  // Frame repeat
  input  wire logic          frame_start,
  output logic [17:0]        frame_count,
  output logic               pattern_restart,
  // Power
  input  wire logic          general_io_zero_in,
  output logic               general_io_zero_out,
  output logic               general_io_zero_oe,
  input  wire logic          general_io_zero_out_req,
  input  wire logic          general_io_zero_oe_req,
  input  wire logic          seq_power_on,
  output logic               power_save,
  output logic               panel_power_out,
  output logic               panel_if_force_low
);
  import lcdm_pkg::*;

  generate
    if (ADDR_W < 4)
    begin : g_chk
      $error("lcdm_mode_ctrl: ADDR_W must be at least 4");
    end
  endgenerate

  // 2'b01 format register, 2'b10 power register, 2'b00 unmapped
  function automatic logic [1:0] reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = {addr == ADDR_W'(LCDM_PWR_ADDR), addr == ADDR_W'(LCDM_FMT_ADDR)};
  endfunction

  // Depth code to log2 of bits per pixel
  function automatic logic [1:0] bpp_log2(input logic [1:0] code);
    bpp_log2 = code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave and registers

  logic [7:0]        fmt_ff, nxt_fmt;
  logic [7:0]        pwr_ff, nxt_pwr;
  logic              aw_hold_ff, nxt_aw_hold;
  logic              w_hold_ff, nxt_w_hold;
  logic [ADDR_W-1:0] waddr_ff, nxt_waddr;
  logic [7:0]        wdata_ff, nxt_wdata;
  logic              wstrb_ff, nxt_wstrb;
  logic              bvalid_ff, nxt_bvalid;
  logic [1:0]        bresp_ff, nxt_bresp;
  logic              rvalid_ff, nxt_rvalid;
  logic [1:0]        rresp_ff, nxt_rresp;
  logic [31:0]       rdata_ff, nxt_rdata;
  logic [1:0]        whit, rhit;

  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  always_comb
  begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_waddr   = waddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff && !s_axi_bready;
    nxt_bresp   = bresp_ff;
    nxt_fmt     = fmt_ff;
    nxt_pwr     = pwr_ff;
    whit        = reg_hit(waddr_ff);
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_hold = 1'b1;
      nxt_waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_hold = 1'b1;
      nxt_wdata  = s_axi_wdata[7:0];
      nxt_wstrb  = s_axi_wstrb[0];
    end
    // Both halves held: commit and answer in one step
    if (aw_hold_ff && w_hold_ff)
    begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (whit != 2'b00) ? LCDM_RESP_OKAY : LCDM_RESP_SLVERR;
      if (wstrb_ff && whit[0])
        nxt_fmt = wdata_ff;
      if (wstrb_ff && whit[1])
        nxt_pwr = wdata_ff & LCDM_PWR_MASK;
    end
  end

  always_comb
  begin
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    rhit       = reg_hit(s_axi_araddr);
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = (rhit != 2'b00) ? LCDM_RESP_OKAY : LCDM_RESP_SLVERR;
      nxt_rdata  = rhit[0] ? {24'h000000, fmt_ff} : rhit[1] ? {24'h000000, pwr_ff} : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fmt_ff     <= LCDM_FMT_RST;
      pwr_ff     <= LCDM_PWR_RST;
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      waddr_ff   <= '0;
      wdata_ff   <= 8'h00;
      wstrb_ff   <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= LCDM_RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= LCDM_RESP_OKAY;
      rdata_ff   <= 32'h00000000;
    end
    else
    begin
      fmt_ff     <= nxt_fmt;
      pwr_ff     <= nxt_pwr;
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      waddr_ff   <= nxt_waddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Depth decode and clock ticks

  logic       high_perf;
  logic       clk_half;
  logic [1:0] mem_div_sel;
  logic       mem_div_tick;

  assign bpp_code       = fmt_ff[LCDM_BPP_LO +: 2];
  assign bits_per_pixel = 4'(1 << bpp_log2(bpp_code));
  assign depth_reserved = !color_panel && (bpp_code == LCDM_BPP_8);
  assign high_perf      = fmt_ff[LCDM_HPERF];
  assign clk_half       = fmt_ff[LCDM_CLK_HALF];
  // Narrow depths need fewer memory fetches per pixel; divide to save power
  assign mem_div_sel    = high_perf ? 2'h0 : 2'(2'h3 - bpp_log2(bpp_code));

  lcdm_tick_div #(.SEL_W(1)) u_op_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick_in  (1'b1),
    .div_sel  (clk_half),
    .tick_out (op_clk_tick)
  );

  assign pixel_clk_tick = op_clk_tick;

  lcdm_tick_div #(.SEL_W(2)) u_mem_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .tick_in  (pixel_clk_tick),
    .div_sel  (mem_div_sel),
    .tick_out (mem_div_tick)
  );

  assign mem_clk_tick = rotated_view ? rotated_mem_tick : mem_div_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Power control and io zero

  logic hw_ps;

  assign hw_ps               = pwr_ff[LCDM_HW_PS_EN] && general_io_zero_in;
  assign general_io_zero_oe  = !pwr_ff[LCDM_HW_PS_EN] && general_io_zero_oe_req;
  assign general_io_zero_out = general_io_zero_out_req;
  assign power_save          = (pwr_ff[LCDM_SW_PS_LO +: 2] == LCDM_SWPS_SAVE) || hw_ps;
  assign panel_if_force_low  = pwr_ff[LCDM_PWR_OVR] && power_save;
  assign panel_power_out     = seq_power_on && !panel_if_force_low;

  ////////////////////////////////////////////////////////////////////////////
  // Pixel path

  logic        passive_hw_inv;
  logic [11:0] pix_ff, nxt_pix;

  assign passive_hw_inv = !active_panel && fmt_ff[LCDM_HW_INV];
  assign video_invert   = passive_hw_inv ? panel_pixel_bit_eleven_in : fmt_ff[LCDM_SW_INV];
  assign general_io_four_in = panel_pixel_bit_eleven_in;

  always_comb
  begin
    nxt_pix = lut_pixel ^ {12{video_invert}};
    if (fmt_ff[LCDM_BLANK] || panel_if_force_low)
      nxt_pix = 12'h000;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      pix_ff <= 12'h000;
    else
      pix_ff <= nxt_pix;
  end

  assign panel_pixel_lines = pix_ff[10:0];
  // Bit eleven: pixel data on active panels, invert input or io four on passive
  assign panel_pixel_bit_eleven_oe  = active_panel || (!fmt_ff[LCDM_HW_INV] && general_io_four_oe_req);
  assign panel_pixel_bit_eleven_out = active_panel ? pix_ff[11] : general_io_four_out_req;

  ////////////////////////////////////////////////////////////////////////////
  // Frame repeat counter

  logic [17:0] frame_ff, nxt_frame;
  logic        restart_ff, nxt_restart;

  always_comb
  begin
    nxt_frame   = frame_ff;
    nxt_restart = 1'b0;
    if (frame_start)
    begin
      nxt_frame = 18'(frame_ff + 1'b1);
      // Wrap is silent while repeat is off, so the pattern never restarts
      nxt_restart = fmt_ff[LCDM_FRAME_REP] && (frame_ff == LCDM_FRAME_MAX);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_ff   <= 18'h00000;
      restart_ff <= 1'b0;
    end
    else
    begin
      frame_ff   <= nxt_frame;
      restart_ff <= nxt_restart;
    end
  end

  assign frame_count     = frame_ff;
  assign pattern_restart = restart_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic [3:0] pix_gap_ff;
  logic       gap_ok_ff;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pix_gap_ff <= 4'h0;
      gap_ok_ff  <= 1'b0;
    end
    else
    begin
      pix_gap_ff <= mem_clk_tick ? 4'h0 : 4'(pix_gap_ff + pixel_clk_tick);
      gap_ok_ff  <= (nxt_fmt == fmt_ff) && !rotated_view && (gap_ok_ff || mem_clk_tick);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_mem_ratio: assert property (mem_clk_tick && gap_ok_ff && pixel_clk_tick |->
    5'(pix_gap_ff) + 5'h01 == 5'(1 << mem_div_sel)) else $error("memory tick ratio wrong");
  a_hperf_equal: assert property (high_perf && !rotated_view && pixel_clk_tick |-> mem_clk_tick)
    else $error("memory tick missing in high performance");
  a_rot_select: assert property (rotated_view |-> mem_clk_tick == rotated_mem_tick)
    else $error("rotated view memory tick not selected");
  a_half_clock: assert property (clk_half && $past(clk_half) |-> op_clk_tick != $past(op_clk_tick))
    else $error("operating tick not halved");
  a_full_clock: assert property (!clk_half |-> op_clk_tick && pixel_clk_tick)
    else $error("operating tick not every cycle");
  a_blank_low: assert property ($past(fmt_ff[LCDM_BLANK]) |-> panel_pixel_lines == 11'h000)
    else $error("pixel lines not low while blanked");
  a_invert_data: assert property (!$past(fmt_ff[LCDM_BLANK]) && !$past(panel_if_force_low) |->
    pix_ff == ($past(lut_pixel) ^ {12{$past(video_invert)}})) else $error("pixel inversion wrong");
  a_hw_inv_sel: assert property (passive_hw_inv |-> video_invert == panel_pixel_bit_eleven_in)
    else $error("hardware invert not taken from pin");
  a_hw_inv_pin: assert property (passive_hw_inv |-> !panel_pixel_bit_eleven_oe)
    else $error("invert pin driven");
  a_frame_wrap: assert property (frame_start && fmt_ff[LCDM_FRAME_REP] && frame_ff == LCDM_FRAME_MAX |=>
    frame_ff == 18'h00000 && pattern_restart ##1 !pattern_restart) else $error("frame wrap wrong");
  a_no_repeat: assert property (!$past(fmt_ff[LCDM_FRAME_REP]) |-> !pattern_restart)
    else $error("pattern restarted with repeat off");
  a_power_off: assert property (pwr_ff[LCDM_PWR_OVR] && power_save |-> !panel_power_out ##1
    (panel_pixel_lines == 11'h000 || !$past(pwr_ff[LCDM_PWR_OVR]))) else $error("override power off wrong");
  a_io0_input: assert property (pwr_ff[LCDM_HW_PS_EN] && general_io_zero_in |-> power_save &&
    !general_io_zero_oe) else $error("io zero power save wrong");
  a_swps_run: assert property (pwr_ff[1:0] == LCDM_SWPS_RUN && !hw_ps |-> !power_save)
    else $error("power save in normal code");
  a_read_back: assert property (s_axi_arvalid && s_axi_arready && reg_hit(s_axi_araddr) == 2'b10 |=>
    s_axi_rvalid && s_axi_rdata == {24'h000000, $past(pwr_ff) & LCDM_PWR_MASK}) else $error("readback wrong");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_read_done:  cover property (s_axi_rvalid && s_axi_rready);
  c_restart:    cover property (pattern_restart);
  c_div8_tick:  cover property (mem_clk_tick && gap_ok_ff && mem_div_sel == 2'h3);
endmodule

/* File: lcdm_pin_model.sv */
/*
  Board-side model of the two shared pins: pixel bit eleven and io zero.
  Assumes the bench sets the board-side levels after a rising edge.
*/
`timescale 1ns/1ps
module lcdm_pin_model (
  input  wire logic pin11_out,
  input  wire logic pin11_oe,
  input  wire logic inv_level,
  output logic      pin11_in,
  input  wire logic io0_out,
  input  wire logic io0_oe,
  input  wire logic ps_level,
  output logic      io0_in
);
  // Board drives only while the block has released the pin
  assign pin11_in = pin11_oe ? pin11_out : inv_level;
  assign io0_in   = io0_oe ? io0_out : ps_level;
endmodule

/* File: tb_lcd_display_mode_control.sv */
/*
  Self-checking bench for the display mode control block.
  Assumes the pin model on the far side and a 50 MHz core clock.
*/
`timescale 1ns/1ps
module tb_lcd_display_mode_control;
  import lcdm_pkg::*;
  logic        core_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, f;
  logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, v;
  logic [3:0]  s_axi_wstrb, bits_per_pixel, ws;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bpp_code, rs;
  logic        color_panel, active_panel, rotated_view, rotated_mem_tick, depth_reserved, e;
  logic        op_clk_tick, pixel_clk_tick, mem_clk_tick, video_invert, frame_start, pattern_restart;
  logic [11:0] lut_pixel;
  logic [10:0] panel_pixel_lines;
  logic        panel_pixel_bit_eleven_in, panel_pixel_bit_eleven_out, panel_pixel_bit_eleven_oe;
  logic        general_io_four_out_req, general_io_four_oe_req, general_io_four_in;
  logic [17:0] frame_count, c;
  logic        general_io_zero_in, general_io_zero_out, general_io_zero_oe, general_io_zero_out_req;
  logic        general_io_zero_oe_req, seq_power_on, power_save, panel_power_out, panel_if_force_low;
  logic        inv_level, ps_level;
  int          bad_count, samples_checked, o, p, m;
  ////////////////////////////////////////////////////////////////
  lcdm_mode_ctrl #(.ADDR_W(8)) uut (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .color_panel, .active_panel, .rotated_view, .rotated_mem_tick, .bpp_code,
    .bits_per_pixel, .depth_reserved, .op_clk_tick, .pixel_clk_tick, .mem_clk_tick, .lut_pixel,
    .panel_pixel_lines, .panel_pixel_bit_eleven_in, .panel_pixel_bit_eleven_out,
    .panel_pixel_bit_eleven_oe, .general_io_four_out_req, .general_io_four_oe_req, .general_io_four_in,
    .video_invert, .frame_start, .frame_count, .pattern_restart, .general_io_zero_in,
    .general_io_zero_out, .general_io_zero_oe, .general_io_zero_out_req, .general_io_zero_oe_req,
    .seq_power_on, .power_save, .panel_power_out, .panel_if_force_low);
  lcdm_pin_model pm (.pin11_out(panel_pixel_bit_eleven_out), .pin11_oe(panel_pixel_bit_eleven_oe),
    .inv_level, .pin11_in(panel_pixel_bit_eleven_in), .io0_out(general_io_zero_out),
    .io0_oe(general_io_zero_oe), .ps_level, .io0_in(general_io_zero_in));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Run needs a few thousand cycles; 20k is ample margin
  initial
  begin
    #(400_000);
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Pin level rules only on passive panels with hardware invert on
  function automatic logic inv_exp(input logic hw, input logic act, input logic lvl, input logic sw);
    return (hw && !act) ? lvl : sw;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Ready and valid sampled mid-cycle, released just after the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    int n;
    n = 0;
    hb = 1'b0;
    r = 2'h1;
    v = xs();
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {v[31:8], d};
    s_axi_wstrb <= ws;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!hb && n < 50)
    begin
      @(negedge core_clk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid & s_axi_bready;
      if (hb) r = s_axi_bresp;
      @(posedge core_clk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      n++;
    end
    if (!hb) bad_count++;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    int n;
    n = 0;
    hr = 1'b0;
    r = 2'h1;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!hr && n < 50)
    begin
      @(negedge core_clk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid & s_axi_rready;
      if (hr) d = s_axi_rdata;
      if (hr) r = s_axi_rresp;
      @(posedge core_clk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      n++;
    end
    if (!hr) bad_count++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axi_wr(a, d, rs);
    check(rs, LCDM_RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    axi_rd(a, rd, rs);
    check(rs, LCDM_RESP_OKAY);
    check(rd, x);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h7433;
    bad_count = 0;
    samples_checked = 0;
    ws = 4'hF;
    rst_b = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {active_panel, rotated_view, rotated_mem_tick, lut_pixel, frame_start} = '0;
    {general_io_four_out_req, general_io_four_oe_req, general_io_zero_out_req} = '0;
    {general_io_zero_oe_req, inv_level, ps_level} = '0;
    color_panel = 1'b1;
    seq_power_on = 1'b1;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    check(power_save, 1'b1);
    rd_chk(LCDM_FMT_ADDR, 32'h0);
    rd_chk(LCDM_PWR_ADDR, 32'h0);
    repeat (8)
    begin
      v = xs();
      f = v[7:0];
      wr(LCDM_FMT_ADDR, f);
      rd_chk(LCDM_FMT_ADDR, {24'h0, f});
      wr(LCDM_PWR_ADDR, ~f);
      rd_chk(LCDM_PWR_ADDR, {24'h0, ~f & LCDM_PWR_MASK});
    end
    axi_wr(8'h10, 8'hFF, rs);
    check(rs, LCDM_RESP_SLVERR);
    axi_rd(8'h10, rd, rs);
    check(rs, LCDM_RESP_SLVERR);
    check(rd, 32'h0);
    // Low byte strobe clear: answered, register untouched
    ws = 4'hE;
    axi_wr(LCDM_FMT_ADDR, ~f, rs);
    check(rs, LCDM_RESP_OKAY);
    ws = 4'hF;
    rd_chk(LCDM_FMT_ADDR, {24'h0, f});
    wr(LCDM_PWR_ADDR, 8'h03);
    // Every depth, both speeds, both input divides
    for (int k = 0; k < 16; k++)
    begin
      wr(LCDM_FMT_ADDR, {k[1:0], k[2], k[3], 4'h0});
      repeat (16) @(posedge core_clk);
      o = 0;
      p = 0;
      m = 0;
      repeat (64)
      begin
        @(negedge core_clk);
        o += (op_clk_tick === 1'b1);
        p += (pixel_clk_tick === 1'b1);
        m += (mem_clk_tick === 1'b1);
      end
      check(bits_per_pixel, 4'h1 << k[1:0]);
      check(bpp_code, k[1:0]);
      check(depth_reserved, 1'b0);
      check(o, k[3] ? 32 : 64);
      check(p, o);
      check(m, k[2] ? p : p >> (3 - k[1:0]));
    end
    @(posedge core_clk);
    color_panel <= 1'b0;
    @(negedge core_clk);
    check(depth_reserved, 1'b1);
    @(posedge core_clk);
    color_panel <= 1'b1;
    rotated_view <= 1'b1;
    repeat (32)
    begin
      @(posedge core_clk);
      v = xs();
      rotated_mem_tick <= v[0];
      @(negedge core_clk);
      check(mem_clk_tick, rotated_mem_tick);
    end
    @(posedge core_clk);
    rotated_view <= 1'b0;
    // Blank, hardware and software invert, panel kind, pin level
    for (int k = 0; k < 32; k++)
    begin
      wr(LCDM_FMT_ADDR, {4'h0, k[0], 1'b0, k[1], k[2]});
      @(posedge core_clk);
      active_panel <= k[3];
      inv_level <= k[4];
      v = xs();
      general_io_four_out_req <= v[0];
      general_io_four_oe_req <= v[1];
      @(negedge core_clk);
      e = inv_exp(k[1], k[3], k[4], k[2]);
      check(video_invert, e);
      if (!k[3]) check(panel_pixel_bit_eleven_oe, k[1] ? 1'b0 : v[1]);
      if (!k[3]) check(general_io_four_in, (!k[1] && v[1]) ? v[0] : k[4]);
      repeat (4)
      begin
        @(posedge core_clk);
        v = xs();
        lut_pixel <= v[11:0];
        @(posedge core_clk);
        @(negedge core_clk);
        check(panel_pixel_lines, k[0] ? 11'h0 : v[10:0] ^ {11{e}});
      end
    end
    // Wrap at full count needs 2**18 frames, beyond this run's budget
    wr(LCDM_FMT_ADDR, 8'h04);
    @(negedge core_clk);
    c = frame_count;
    repeat (6)
    begin
      @(posedge core_clk);
      frame_start <= 1'b1;
      @(posedge core_clk);
      frame_start <= 1'b0;
      @(negedge core_clk);
      c = c + 18'h1;
      check(frame_count, c);
      check(pattern_restart, 1'b0);
    end
    for (int k = 0; k < 32; k++)
    begin
      wr(LCDM_PWR_ADDR, {4'h0, k[3:0]});
      @(posedge core_clk);
      v = xs();
      ps_level <= k[4];
      seq_power_on <= v[0];
      general_io_zero_oe_req <= v[1];
      general_io_zero_out_req <= v[2];
      lut_pixel <= 12'hFFF;
      @(posedge core_clk);
      @(negedge core_clk);
      e = (k[1:0] == 2'h0) || (k[2] && k[4]);
      check(power_save, e);
      check(panel_if_force_low, k[3] & e);
      check(panel_power_out, v[0] & !(k[3] & e));
      check(general_io_zero_oe, k[2] ? 1'b0 : v[1]);
      check(general_io_zero_out, v[2]);
      check(panel_pixel_lines, (k[3] & e) ? 11'h0 : 11'h7FF);
    end
    conclude();
  end
endmodule
